// ==== src/urc_device.sv ====
// Device end: transmitter, receiver and 1024-byte receive buffer with RTS/CTS
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Eight data bits, one stop, no parity
// - Runs at two megabits, handshake active
// - Transmit and receive run independently, concurrently
// - RTS driven out, CTS sampled; both low-active
// - Both data lines idle high
// - New frames held while CTS deasserted; RTS signals host
// - Host must not send while RTS deasserted
// - Receive buffer holds 1024 bytes
// - Serial output drives high after reset
// - RTS drives low after reset
// - Receive and CTS inputs pulled up
module urc_device (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  urc_link_if.dev         link,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic            rx_frame_err_out,
  output logic            rx_overrun_out
);

  // ************************************************************
  // Transmitter
  // ************************************************************
  urc_pkg::urc_phase_e                tx_state;
  urc_pkg::urc_phase_e                next_tx_state;
  logic [urc_pkg::CNT_W-1:0]          tx_cnt;
  logic [urc_pkg::CNT_W-1:0]          next_tx_cnt;
  logic [urc_pkg::IDX_W-1:0]          tx_idx;
  logic [urc_pkg::IDX_W-1:0]          next_tx_idx;
  logic [7:0]                         tx_shift;
  logic [7:0]                         next_tx_shift;
  logic                               tx_line;
  logic                               next_tx_line;
  logic                               tx_ready;
  logic                               next_tx_ready;
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_idx   = tx_idx;
    next_tx_shift = tx_shift;
    next_tx_line  = tx_line;
    next_tx_ready = tx_ready;
    unique case (tx_state)
      urc_pkg::ST_IDLE: begin
        if (tx_valid_in && tx_ready) begin
          next_tx_shift = tx_data_in;
          next_tx_line  = urc_pkg::LINE_START;
          next_tx_cnt   = '0;
          next_tx_ready = 1'b0;
          next_tx_state = urc_pkg::ST_START;
        end else begin
          // CTS gates only the start of a frame; a frame in flight completes
          next_tx_ready = (link.dev_cts_n == urc_pkg::HS_ASSERT);
        end
      end
      urc_pkg::ST_START: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt   = '0;
          next_tx_idx   = '0;
          next_tx_line  = tx_shift[0];
          next_tx_state = urc_pkg::ST_DATA;
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_DATA: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt = '0;
          if (urc_pkg::urc_last_bit(tx_idx)) begin
            next_tx_line  = urc_pkg::LINE_IDLE;
            next_tx_state = urc_pkg::ST_STOP;
          end else begin
            next_tx_idx   = tx_idx + 3'h1;
            next_tx_shift = {1'b0, tx_shift[7:1]};
            next_tx_line  = tx_shift[1];
          end
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_STOP: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt   = '0;
          next_tx_state = urc_pkg::ST_IDLE;
          next_tx_ready = (link.dev_cts_n == urc_pkg::HS_ASSERT);
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_state <= urc_pkg::ST_IDLE;
      tx_cnt   <= '0;
      tx_idx   <= '0;
      tx_shift <= '0;
      tx_line  <= urc_pkg::LINE_IDLE;
      tx_ready <= 1'b0;
    end else if (ce_in) begin
      tx_state <= next_tx_state;
      tx_cnt   <= next_tx_cnt;
      tx_idx   <= next_tx_idx;
      tx_shift <= next_tx_shift;
      tx_line  <= next_tx_line;
      tx_ready <= next_tx_ready;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  urc_pkg::urc_phase_e                rx_state;
  urc_pkg::urc_phase_e                next_rx_state;
  logic [urc_pkg::CNT_W-1:0]          rx_cnt;
  logic [urc_pkg::CNT_W-1:0]          next_rx_cnt;
  logic [urc_pkg::IDX_W-1:0]          rx_idx;
  logic [urc_pkg::IDX_W-1:0]          next_rx_idx;
  logic [7:0]                         rx_shift;
  logic [7:0]                         next_rx_shift;
  logic                               rx_push;
  logic                               rx_ferr;
  logic                               next_rx_ferr;
  // Separate state from the transmitter: both directions run at once
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_idx   = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_ferr  = 1'b0;
    rx_push       = 1'b0;
    unique case (rx_state)
      urc_pkg::ST_IDLE: begin
        if (link.dev_rxd == urc_pkg::LINE_START) begin
          next_rx_cnt   = '0;
          next_rx_state = urc_pkg::ST_START;
        end
      end
      urc_pkg::ST_START: begin
        if (urc_pkg::urc_half_done(rx_cnt)) begin
          next_rx_cnt = '0;
          next_rx_idx = '0;
          // A glitch shorter than half a bit is not a start bit
          next_rx_state = (link.dev_rxd == urc_pkg::LINE_START) ?
                          urc_pkg::ST_DATA : urc_pkg::ST_IDLE;
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_DATA: begin
        if (urc_pkg::urc_bit_done(rx_cnt)) begin
          next_rx_cnt   = '0;
          next_rx_shift = {link.dev_rxd, rx_shift[7:1]};
          if (urc_pkg::urc_last_bit(rx_idx)) begin
            next_rx_state = urc_pkg::ST_STOP;
          end else begin
            next_rx_idx = rx_idx + 3'h1;
          end
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_STOP: begin
        if (urc_pkg::urc_bit_done(rx_cnt)) begin
          // Back to idle at mid stop bit, ready for the next start edge
          next_rx_cnt   = '0;
          next_rx_state = urc_pkg::ST_IDLE;
          rx_push       = (link.dev_rxd == urc_pkg::LINE_IDLE);
          next_rx_ferr  = (link.dev_rxd != urc_pkg::LINE_IDLE);
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_state <= urc_pkg::ST_IDLE;
      rx_cnt   <= '0;
      rx_idx   <= '0;
      rx_shift <= '0;
      rx_ferr  <= 1'b0;
    end else if (ce_in) begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_idx   <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_ferr  <= next_rx_ferr;
    end
  end

  // ************************************************************
  // Receive buffer and request-to-send
  // ************************************************************
  logic [7:0]                         buf_mem [urc_pkg::RX_BUF_DEPTH];
  logic [urc_pkg::RX_BUF_AW-1:0]      wr_ptr;
  logic [urc_pkg::RX_BUF_AW-1:0]      next_wr_ptr;
  logic [urc_pkg::RX_BUF_AW-1:0]      rd_ptr;
  logic [urc_pkg::RX_BUF_AW-1:0]      next_rd_ptr;
  logic [urc_pkg::RX_BUF_AW:0]        fill;
  logic [urc_pkg::RX_BUF_AW:0]        next_fill;
  logic [7:0]                         out_data;
  logic [7:0]                         next_out_data;
  logic                               out_valid;
  logic                               next_out_valid;
  logic                               rts_n;
  logic                               next_rts_n;
  logic                               ovr;
  logic                               next_ovr;
  logic                               wr_en;
  logic                               rd_en;
  always_comb begin
    wr_en          = rx_push && (fill != (urc_pkg::RX_BUF_AW+1)'(urc_pkg::RX_BUF_DEPTH));
    next_ovr       = rx_push && !wr_en;
    rd_en          = (fill != '0) && (!out_valid || rx_ready_in);
    next_wr_ptr    = wr_en ? wr_ptr + 10'h001 : wr_ptr;
    next_rd_ptr    = rd_en ? rd_ptr + 10'h001 : rd_ptr;
    next_out_data  = rd_en ? buf_mem[rd_ptr] : out_data;
    next_out_valid = rd_en || (out_valid && !rx_ready_in);
    next_fill      = fill;
    if (wr_en && !rd_en) begin
      next_fill = fill + 11'h001;
    end else if (rd_en && !wr_en) begin
      next_fill = fill - 11'h001;
    end
    // Margin leaves room for frames the host had already started
    next_rts_n = (next_fill >= (urc_pkg::RX_BUF_AW+1)'(urc_pkg::RX_BUF_DEPTH -
                  urc_pkg::RTS_MARGIN)) ? urc_pkg::HS_DEASSERT : urc_pkg::HS_ASSERT;
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fill      <= '0;
      out_data  <= '0;
      out_valid <= 1'b0;
      rts_n     <= urc_pkg::HS_ASSERT;
      ovr       <= 1'b0;
    end else if (ce_in) begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      fill      <= next_fill;
      out_data  <= next_out_data;
      out_valid <= next_out_valid;
      rts_n     <= next_rts_n;
      ovr       <= next_ovr;
      if (wr_en) begin
        buf_mem[wr_ptr] <= rx_shift;
      end
    end
  end

  assign link.dev_txd     = tx_line;
  assign link.dev_rts_n   = rts_n;
  assign tx_ready_out     = tx_ready;
  assign rx_data_out      = out_data;
  assign rx_valid_out     = out_valid;
  assign rx_frame_err_out = rx_ferr;
  assign rx_overrun_out   = ovr;
endmodule : urc_device
`default_nettype wire

// ==== src/urc_host.sv ====
// Host end: transmitter honouring the device RTS, receiver driving the device CTS
`timescale 1ns/10ps
`default_nettype none
module urc_host (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  urc_link_if.host        link,
  input  wire logic       drive_en_in,
  input  wire logic       rx_hold_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_frame_err_out
);

  // ************************************************************
  // Transmitter
  // ************************************************************
  urc_pkg::urc_phase_e                tx_state;
  urc_pkg::urc_phase_e                next_tx_state;
  logic [urc_pkg::CNT_W-1:0]          tx_cnt;
  logic [urc_pkg::CNT_W-1:0]          next_tx_cnt;
  logic [urc_pkg::IDX_W-1:0]          tx_idx;
  logic [urc_pkg::IDX_W-1:0]          next_tx_idx;
  logic [7:0]                         tx_shift;
  logic [7:0]                         next_tx_shift;
  logic                               tx_line;
  logic                               next_tx_line;
  logic                               tx_ready;
  logic                               next_tx_ready;
  logic                               can_send;

  always_comb begin
    // A deasserted device RTS holds off new frames
    can_send      = (link.dev_rts_n == urc_pkg::HS_ASSERT) && drive_en_in;
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_idx   = tx_idx;
    next_tx_shift = tx_shift;
    next_tx_line  = tx_line;
    next_tx_ready = tx_ready;
    unique case (tx_state)
      urc_pkg::ST_IDLE: begin
        if (tx_valid_in && tx_ready) begin
          next_tx_shift = tx_data_in;
          next_tx_line  = urc_pkg::LINE_START;
          next_tx_cnt   = '0;
          next_tx_ready = 1'b0;
          next_tx_state = urc_pkg::ST_START;
        end else begin
          next_tx_ready = can_send;
        end
      end
      urc_pkg::ST_START: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt   = '0;
          next_tx_idx   = '0;
          next_tx_line  = tx_shift[0];
          next_tx_state = urc_pkg::ST_DATA;
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_DATA: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt = '0;
          if (urc_pkg::urc_last_bit(tx_idx)) begin
            next_tx_line  = urc_pkg::LINE_IDLE;
            next_tx_state = urc_pkg::ST_STOP;
          end else begin
            next_tx_idx   = tx_idx + 3'h1;
            next_tx_shift = {1'b0, tx_shift[7:1]};
            next_tx_line  = tx_shift[1];
          end
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_STOP: begin
        if (urc_pkg::urc_bit_done(tx_cnt)) begin
          next_tx_cnt   = '0;
          next_tx_state = urc_pkg::ST_IDLE;
          next_tx_ready = can_send;
        end else begin
          next_tx_cnt = tx_cnt + 6'h01;
        end
      end
    endcase
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  urc_pkg::urc_phase_e                rx_state;
  urc_pkg::urc_phase_e                next_rx_state;
  logic [urc_pkg::CNT_W-1:0]          rx_cnt;
  logic [urc_pkg::CNT_W-1:0]          next_rx_cnt;
  logic [urc_pkg::IDX_W-1:0]          rx_idx;
  logic [urc_pkg::IDX_W-1:0]          next_rx_idx;
  logic [7:0]                         rx_shift;
  logic [7:0]                         next_rx_shift;
  logic [7:0]                         rx_data;
  logic [7:0]                         next_rx_data;
  logic                               rx_valid;
  logic                               next_rx_valid;
  logic                               rx_ferr;
  logic                               next_rx_ferr;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_idx   = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_data  = rx_data;
    next_rx_valid = 1'b0;
    next_rx_ferr  = 1'b0;
    unique case (rx_state)
      urc_pkg::ST_IDLE: begin
        if (link.dev_txd == urc_pkg::LINE_START) begin
          next_rx_cnt   = '0;
          next_rx_state = urc_pkg::ST_START;
        end
      end
      urc_pkg::ST_START: begin
        if (urc_pkg::urc_half_done(rx_cnt)) begin
          next_rx_cnt   = '0;
          next_rx_idx   = '0;
          next_rx_state = (link.dev_txd == urc_pkg::LINE_START) ?
                          urc_pkg::ST_DATA : urc_pkg::ST_IDLE;
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_DATA: begin
        if (urc_pkg::urc_bit_done(rx_cnt)) begin
          next_rx_cnt   = '0;
          next_rx_shift = {link.dev_txd, rx_shift[7:1]};
          if (urc_pkg::urc_last_bit(rx_idx)) begin
            next_rx_state = urc_pkg::ST_STOP;
          end else begin
            next_rx_idx = rx_idx + 3'h1;
          end
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
      urc_pkg::ST_STOP: begin
        if (urc_pkg::urc_bit_done(rx_cnt)) begin
          next_rx_cnt   = '0;
          next_rx_state = urc_pkg::ST_IDLE;
          next_rx_data  = rx_shift;
          next_rx_valid = (link.dev_txd == urc_pkg::LINE_IDLE);
          next_rx_ferr  = (link.dev_txd != urc_pkg::LINE_IDLE);
        end else begin
          next_rx_cnt = rx_cnt + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_state <= urc_pkg::ST_IDLE;
      tx_cnt   <= '0;
      tx_idx   <= '0;
      tx_shift <= '0;
      tx_line  <= urc_pkg::LINE_IDLE;
      tx_ready <= 1'b0;
      rx_state <= urc_pkg::ST_IDLE;
      rx_cnt   <= '0;
      rx_idx   <= '0;
      rx_shift <= '0;
      rx_data  <= '0;
      rx_valid <= 1'b0;
      rx_ferr  <= 1'b0;
    end else if (ce_in) begin
      tx_state <= next_tx_state;
      tx_cnt   <= next_tx_cnt;
      tx_idx   <= next_tx_idx;
      tx_shift <= next_tx_shift;
      tx_line  <= next_tx_line;
      tx_ready <= next_tx_ready;
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_idx   <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_data  <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_ferr  <= next_rx_ferr;
    end
  end

  // ************************************************************
  // Pin drive and handshake out
  // ************************************************************
  logic                               drv_oe;
  logic                               cts_n;
  logic                               next_cts_n;

  always_comb begin
    next_cts_n = rx_hold_in ? urc_pkg::HS_DEASSERT : urc_pkg::HS_ASSERT;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      drv_oe <= urc_pkg::RST_OE;
      cts_n  <= urc_pkg::HS_DEASSERT;
    end else if (ce_in) begin
      drv_oe <= drive_en_in;
      cts_n  <= next_cts_n;
    end
  end

  assign link.host_txd    = tx_line;
  assign link.host_txd_oe = drv_oe;
  assign link.host_cts_n  = cts_n;
  assign link.host_cts_oe = drv_oe;
  assign tx_ready_out     = tx_ready;
  assign rx_data_out      = rx_data;
  assign rx_valid_out     = rx_valid;
  assign rx_frame_err_out = rx_ferr;

endmodule : urc_host
`default_nettype wire

// ==== src/urc_link_if.sv ====
// Serial link between the port and its host, with pull-ups on host-driven lines
`timescale 1ns/10ps
`default_nettype none
interface urc_link_if;
  logic dev_txd;
  logic dev_rts_n;
  logic host_txd;
  logic host_txd_oe;
  logic host_cts_n;
  logic host_cts_oe;
  logic dev_rxd;
  logic dev_cts_n;

  // Undriven inputs read idle and deasserted
  assign dev_rxd   = host_txd_oe ? host_txd : 1'b1;
  assign dev_cts_n = host_cts_oe ? host_cts_n : 1'b1;

  modport dev (
    output dev_txd,
    output dev_rts_n,
    input  dev_rxd,
    input  dev_cts_n
  );

  modport host (
    output host_txd,
    output host_txd_oe,
    output host_cts_n,
    output host_cts_oe,
    input  dev_txd,
    input  dev_rts_n
  );
endinterface : urc_link_if
`default_nettype wire

// ==== src/urc_pkg.sv ====
// Shared constants, states and helpers for the serial port with handshake
package urc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BIT_RATE_BPS = 2_000_000;
  localparam int unsigned BIT_CYC      = CLK_HZ / BIT_RATE_BPS;
  localparam int unsigned HALF_BIT_CYC = BIT_CYC / 2;
  localparam int unsigned CNT_W        = 6;

  // ************************************************************
  // Framing and buffering
  // ************************************************************
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned STOP_BITS    = 1;
  localparam int unsigned IDX_W        = 3;
  localparam int unsigned RX_BUF_DEPTH = 1024;
  localparam int unsigned RX_BUF_AW    = 10;
  localparam int unsigned RTS_MARGIN   = 4;
  localparam logic        LINE_IDLE    = 1'b1;
  localparam logic        LINE_START   = 1'b0;
  localparam logic        HS_ASSERT    = 1'b0;
  localparam logic        HS_DEASSERT  = 1'b1;
  localparam logic        RST_OE       = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_STOP
  } urc_phase_e;

  // End of one whole bit period
  function automatic logic urc_bit_done(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(BIT_CYC - 1);
  endfunction : urc_bit_done

  // Middle of the start bit
  function automatic logic urc_half_done(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(HALF_BIT_CYC - 1);
  endfunction : urc_half_done

  function automatic logic urc_last_bit(input logic [IDX_W-1:0] idx);
    return idx == IDX_W'(DATA_BITS - 1);
  endfunction : urc_last_bit

endpackage : urc_pkg

// ==== testbench/uart_rts_cts_port_bench.sv ====
// Bench: both ends joined over the link, held traffic device to host, random traffic both ways
`timescale 1ns/10ps
`default_nettype none
module uart_rts_cts_port_bench;
  logic        clk_in, sys_rst_in, drive_en, rx_hold;
  logic [7:0]  d_tx_data, d_rx_data, h_tx_data, h_rx_data;
  logic        d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, d_ferr, d_ovr;
  logic        h_tx_valid, h_tx_ready, h_rx_valid, h_ferr;
  logic [15:0] rnd;
  logic [7:0]  qd[$], qh[$];
  int          n_errors, tests_run;
  urc_link_if link ();
  urc_device i_urc_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .link(link),
    .tx_data_in(d_tx_data), .tx_valid_in(d_tx_valid), .tx_ready_out(d_tx_ready),
    .rx_data_out(d_rx_data), .rx_valid_out(d_rx_valid), .rx_ready_in(d_rx_ready),
    .rx_frame_err_out(d_ferr), .rx_overrun_out(d_ovr));
  urc_host i_urc_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .link(link),
    .drive_en_in(drive_en), .rx_hold_in(rx_hold), .tx_data_in(h_tx_data),
    .tx_valid_in(h_tx_valid), .tx_ready_out(h_tx_ready), .rx_data_out(h_rx_data),
    .rx_valid_out(h_rx_valid), .rx_frame_err_out(h_ferr));
  urc_link_properties i_urc_link_properties (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .dev_txd(link.dev_txd), .dev_rts_n(link.dev_rts_n), .dev_cts_n(link.dev_cts_n),
    .host_txd(link.host_txd), .host_txd_oe(link.host_txd_oe), .host_cts_n(link.host_cts_n));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Valid left high on return; caller releases it, so no double drive in one step
  task automatic send(input bit dv, input logic [7:0] b);
    int n;
    if (dv) begin
      qh.push_back(b);
      d_tx_data <= b;
      d_tx_valid <= 1'b1;
    end else begin
      qd.push_back(b);
      h_tx_data <= b;
      h_tx_valid <= 1'b1;
    end
    for (n = 0; n < 4000; n++) begin
      @(negedge clk_in);
      if ((dv ? d_tx_ready : h_tx_ready) === 1'b1) break;
    end
    if (n == 4000) n_errors++;
    if (n == 4000) report_and_stop();
    @(posedge clk_in);
  endtask : send
  task automatic drain();
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk_in);
      if (qh.size() + qd.size() == 0) break;
    end
    if (n == 20000) n_errors++;
    if (n == 20000) report_and_stop();
  endtask : drain
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Random consumer stall on the device receive side
  always @(posedge clk_in) begin
    rnd <= lfsr(rnd);
    d_rx_ready <= rnd[0] | rnd[3];
  end
  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge clk_in) begin
    if (h_rx_valid === 1'b1)
      chk("host rx", h_rx_data, qh.size() ? qh.pop_front() : 8'hxx);
    if ((d_rx_valid & d_rx_ready) === 1'b1)
      chk("dev rx", d_rx_data, qd.size() ? qd.pop_front() : 8'hxx);
    // Pulse outputs are unknown until the first reset edge has passed
    if (!sys_rst_in && {d_ferr, d_ovr, h_ferr} !== 3'h0)
      chk("errors", {5'h0, d_ferr, d_ovr, h_ferr}, 8'h00);
  end
  initial begin
    {drive_en, rx_hold, d_tx_valid, h_tx_valid, d_rx_ready} = 5'h00;
    {d_tx_data, h_tx_data} = 16'h0000;
    {n_errors, tests_run} = {32'h0, 32'h0};
    rnd = 16'h6a8c;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    chk("reset lines", {6'h00, link.dev_txd, link.dev_rts_n}, 8'h02);
    $display("test reset done");
    @(posedge clk_in);
    fork
      begin
        send(1'b1, 8'ha5);
        d_tx_valid <= 1'b0;
      end
      begin
        repeat (300) @(posedge clk_in);
        chk("pulled up cts", {7'h00, link.dev_txd}, 8'h01);
        drive_en <= 1'b1;
        rx_hold <= 1'b1;
        repeat (300) @(posedge clk_in);
        chk("held cts", {7'h00, link.dev_txd}, 8'h01);
        rx_hold <= 1'b0;
      end
    join
    drain();
    $display("test hold done");
    fork
      begin
        for (int i = 0; i < 8; i++) send(1'b1, (i == 0) ? 8'hff : rnd[7:0]);
        d_tx_valid <= 1'b0;
      end
      begin
        for (int j = 0; j < 8; j++) send(1'b0, (j == 0) ? 8'h00 : rnd[15:8]);
        h_tx_valid <= 1'b0;
      end
    join
    drain();
    repeat (600) @(posedge clk_in);
    $display("test duplex done");
    report_and_stop();
  end
endmodule : uart_rts_cts_port_bench
`default_nettype wire

// ==== testbench/urc_link_properties.sv ====
// Checker for the serial link: framing, reset levels and handshake gating
`timescale 1ns/10ps
`default_nettype none
module urc_link_properties (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic dev_txd,
  input wire logic dev_rts_n,
  input wire logic dev_cts_n,
  input wire logic host_txd,
  input wire logic host_txd_oe,
  input wire logic host_cts_n
);
  localparam int STOP_AT = 450;
  logic [5:0] d_run, h_run;
  logic [8:0] d_pos, h_pos;
  logic       d_prev, h_prev, d_sof, h_sof;
  // Start counted only from idle, so falls inside a frame are not taken for one
  assign d_sof = d_pos == 9'h000 && d_prev && !dev_txd;
  assign h_sof = h_pos == 9'h000 && h_prev && !host_txd;
  always_ff @(posedge clk_in) begin
    d_prev <= dev_txd;
    h_prev <= host_txd;
    d_run  <= sys_rst_in ? 6'h3f : (dev_txd != d_prev) ? 6'h00 : d_run + 6'(d_run != 6'h3f);
    h_run  <= sys_rst_in ? 6'h3f : (host_txd != h_prev) ? 6'h00 : h_run + 6'(h_run != 6'h3f);
    d_pos  <= sys_rst_in ? 9'h000 : d_sof ? 9'h001 :
              (d_pos == 9'h1f3) ? 9'h000 : d_pos + 9'(d_pos != 9'h000);
    h_pos  <= sys_rst_in ? 9'h000 : h_sof ? 9'h001 :
              (h_pos == 9'h1f3) ? 9'h000 : h_pos + 9'(h_pos != 9'h000);
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_dev_rst_idle: assert property ($fell(sys_rst_in) |-> dev_txd && !dev_rts_n)
    else $error("device lines wrong after reset");
  a_host_rst_idle: assert property ($fell(sys_rst_in) |->
    host_txd && host_cts_n && !host_txd_oe)
    else $error("host lines wrong after reset");
  a_dev_bit_width: assert property (dev_txd != d_prev |-> d_run >= 6'h31)
    else $error("device bit shorter than one period");
  a_host_bit_width: assert property (host_txd != h_prev |-> h_run >= 6'h31)
    else $error("host bit shorter than one period");
  a_dev_stop_bit: assert property (d_sof |-> ##[STOP_AT:STOP_AT] dev_txd [*8])
    else $error("device stop bit missing");
  a_host_stop_bit: assert property (h_sof |-> ##[STOP_AT:STOP_AT] host_txd [*8])
    else $error("host stop bit missing");
  // Ready is registered from the handshake one edge before the start is taken
  a_dev_cts_gate: assert property (d_sof |-> $past(dev_cts_n, 2) == 1'b0)
    else $error("device started while clear-to-send deasserted");
  a_host_rts_gate: assert property (h_sof |-> host_txd_oe && $past(dev_rts_n, 2) == 1'b0)
    else $error("host started while request-to-send deasserted");
  c_dev_frame: cover property (d_sof);
  c_host_frame: cover property (h_sof);
  c_cts_held: cover property (host_txd_oe && host_cts_n);
endmodule : urc_link_properties
`default_nettype wire
